// *** core/scmb_device.sv ***
// mailbox device end: command, page registers and synth storage
`timescale 1ns/10ps
`default_nettype none
module scmb_device (
	// clock and reset
	input  wire logic CORE_CLK,
	input  wire logic RST,
	// register link
	scmb_if.dev       LINK,
	// synthesizer outputs
	output var  logic [scmb_pkg::NUM_SYNTH-1:0][31:0] SYNTH_FREQ,
	output var  logic BUSY
);
	import scmb_pkg::*;

	scmb_dev_state_type state_reg;
	scmb_dev_state_type state_next;
	scmb_cfg_type       page_reg;
	scmb_cfg_type       page_next;
	scmb_mask_type      mask_reg;
	scmb_mask_type      mask_next;
	scmb_byte_type      cmd_reg;
	scmb_byte_type      cmd_next;
	scmb_idx_type       idx_reg;
	scmb_idx_type       idx_next;
	scmb_byte_type      rdata_reg;
	scmb_byte_type      rdata_next;
	logic               rvalid_reg;
	logic               busy_reg;
	logic [NUM_SYNTH-1:0][31:0] freq_reg;

	// bank hookup
	logic                         bank_wr;
	scmb_idx_type                 fetch_idx;
	scmb_cfg_type                 fetch_cfg;
	scmb_cfg_type [NUM_SYNTH-1:0] synth_cfg;

	// decoded link strobes
	logic cmd_wr;
	logic mask_wr;
	logic in_read;
	logic in_write;
	logic op_done;
	logic rd_req;
	logic wr_req;
	logic at_cmd;
	logic at_mask;
	logic idle_now;
	logic start_rd;
	logic start_wr;
	logic busy_next;

	assign at_cmd   = (LINK.addr == CMD);
	assign at_mask  = (LINK.addr == MASK_LO);
	assign cmd_wr   = LINK.wr && at_cmd;
	assign mask_wr  = LINK.wr && at_mask;
	assign idle_now = (state_reg == DEV_IDLE);
	assign in_read  = (state_reg == DEV_READ);
	assign in_write = (state_reg == DEV_WRITE);
	assign rd_req   = cmd_reg[CMD_RD_BIT];
	assign wr_req   = cmd_reg[CMD_WR_BIT];

	// read wins, so a write bit given with it is dropped
	assign start_rd = idle_now && rd_req;
	assign start_wr = idle_now && wr_req && !rd_req;

	// read takes one cycle, write walks all five synths
	assign op_done = in_read || (in_write && idx_reg == IDX_LAST);

	// reserved command bits are never stored, so they read zero
	// a fresh host write beats the completion clear
	assign cmd_next = cmd_wr  ? (LINK.wdata & CMD_USED) :
	                  op_done ? CMD_IDLE :
	                  cmd_reg;

	// busy is registered from cmd_next, so it changes on the same edge as the command byte it reports
	assign busy_next = (cmd_next != CMD_IDLE);

	// upper mask byte is reserved
	assign mask_next = mask_wr ? LINK.wdata[NUM_SYNTH-1:0]
	                           : mask_reg;

	// load from bank wins over a host byte write in the same cycle
	assign page_next = in_read ? fetch_cfg :
	                   LINK.wr ? put_byte(page_reg, LINK.addr,
	                                      LINK.wdata) :
	                   page_reg;

	// a multi-bit mask on read fetches the lowest selected synth
	assign fetch_idx = lowest_index(mask_reg);

	// every masked synth gets the full page
	// page bytes written mid-walk reach only the later synths,
	// so the host must hold off until the command reads zero
	assign bank_wr = in_write && mask_reg[idx_reg];

	assign idx_next = in_write ? scmb_idx_type'(idx_reg + 3'h1)
	                           : IDX_FIRST;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			DEV_IDLE: begin
				if (start_rd) begin
					state_next = DEV_READ;
				end else if (start_wr) begin
					state_next = DEV_WRITE;
				end
			end
			DEV_READ: begin
				state_next = DEV_IDLE;
			end
			DEV_WRITE: begin
				if (op_done) begin
					state_next = DEV_IDLE;
				end
			end
			default: begin
				state_next = DEV_IDLE;
			end
		endcase
	end

	// register readback, unmapped bytes read zero
	assign rdata_next =
		at_mask ? scmb_byte_type'(mask_reg) :
		at_cmd  ? cmd_reg :
		get_byte(page_reg, LINK.addr);

	scmb_synth_bank i_scmb_synth_bank (
		.clk     (CORE_CLK),
		.rst     (RST),
		.wr_en   (bank_wr),
		.wr_idx  (idx_reg),
		.wr_cfg  (page_reg),
		.rd_idx  (fetch_idx),
		.rd_cfg  (fetch_cfg),
		.all_cfg (synth_cfg)
	);

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			state_reg <= DEV_IDLE;
			page_reg  <= CFG_RESET;
			mask_reg  <= MASK_RESET;
			cmd_reg   <= CMD_IDLE;
			idx_reg   <= IDX_FIRST;
			busy_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			page_reg  <= page_next;
			mask_reg  <= mask_next;
			cmd_reg   <= cmd_next;
			idx_reg   <= idx_next;
			busy_reg  <= busy_next;
		end
	end

	// link answer one cycle after the read strobe
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			rdata_reg  <= BYTE_ZERO;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= LINK.rd;
			if (LINK.rd) begin
				rdata_reg <= rdata_next;
			end
		end
	end

	// divider is deep but only feeds registered status outputs
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			freq_reg <= '0;
		end else begin
			for (int i = 0; i < NUM_SYNTH; i++) begin
				freq_reg[i] <= freq_hz(synth_cfg[i]);
			end
		end
	end

	assign LINK.rdata  = rdata_reg;
	assign LINK.rvalid = rvalid_reg;
	assign SYNTH_FREQ  = freq_reg;
	assign BUSY        = busy_reg;
endmodule
`default_nettype wire

// *** core/scmb_host.sv ***
// host controller end: avalon slave driving the mailbox link
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module scmb_host (
	// clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	// avalon-mm slave
	input  wire logic [2:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	output var  logic [31:0] AVS_READDATA,
	output var  logic        AVS_WAITREQUEST,
	// register link
	scmb_if.host             LINK
);
	import scmb_pkg::*;

	scmb_host_state_type state_reg;
	logic                wait_reg;
	logic [31:0]         rdata_reg;
	scmb_addr_type       acc_addr_reg;
	scmb_byte_type       last_reg;
	logic [31:0]         offset_reg;
	logic                refused_reg;
	logic                poll_reg;
	scmb_cfg_type        shadow_reg;
	scmb_mask_type       smask_reg;
	scmb_addr_type       laddr_reg;
	scmb_byte_type       lwdata_reg;
	logic                lwr_reg;
	logic                lrd_reg;

	logic accept;
	logic take_wr;
	logic idle;
	logic busy;
	logic mb_rd_req;
	logic mb_wr_req;
	logic mb_rd_ok;
	logic mb_wr_ok;
	logic base_ok;
	logic range_ok;
	logic got_answer;
	logic [31:0]        av_rdata;
	logic [63:0]        prod;
	logic signed [63:0] off_ext;
	logic signed [63:0] lo_hz;
	logic signed [63:0] hi_hz;

	assign idle    = (state_reg == H_IDLE);
	assign busy    = !idle;
	// stall every access while a link operation is running
	assign accept  = (AVS_READ || AVS_WRITE) && wait_reg && idle;
	assign take_wr = AVS_WRITE && !wait_reg;
	assign mb_rd_req = take_wr && AVS_ADDRESS == AV_CONTROL
	                   && AVS_WRITEDATA[CTL_MB_RD];
	assign mb_wr_req = take_wr && AVS_ADDRESS == AV_CONTROL
	                   && AVS_WRITEDATA[CTL_MB_WR] && !mb_rd_req;
	assign got_answer = (state_reg == H_WAIT) && LINK.rvalid;

	assign base_ok = (shadow_reg.base != '0)
	    && (REF_HZ % 64'(shadow_reg.base)) == '0;
	assign prod    = 64'(shadow_reg.base) * 64'(shadow_reg.mult)
	                 * 64'(shadow_reg.num);
	assign off_ext = 64'(signed'(offset_reg));
	// shifted window, narrowed by margin on both ends
	assign lo_hz   = signed'(FMIN_HZ) + off_ext
	                 + signed'(MARGIN_HZ);
	assign hi_hz   = signed'(FMAX_HZ) + off_ext
	                 - signed'(MARGIN_HZ);
	assign range_ok = (shadow_reg.den != '0) && (lo_hz > 0)
	    && prod >= 64'(unsigned'(lo_hz)) * 64'(shadow_reg.den)
	    && prod <= 64'(unsigned'(hi_hz)) * 64'(shadow_reg.den);
	assign mb_rd_ok = is_onehot(smask_reg);
	assign mb_wr_ok = base_ok && range_ok;

	assign av_rdata =
		(AVS_ADDRESS == AV_ACC_ADDR) ? 32'(acc_addr_reg) :
		(AVS_ADDRESS == AV_ACC_DATA) ? 32'(last_reg) :
		(AVS_ADDRESS == AV_STATUS)   ? 32'({!range_ok, !base_ok,
		                                     refused_reg, busy}) :
		(AVS_ADDRESS == AV_OFFSET)   ? offset_reg :
		'0;

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			wait_reg  <= 1'b1;
			rdata_reg <= '0;
		end else begin
			wait_reg <= !accept;
			if (accept) begin
				rdata_reg <= av_rdata;
			end
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			state_reg    <= H_IDLE;
			acc_addr_reg <= '0;
			last_reg     <= BYTE_ZERO;
			offset_reg   <= '0;
			refused_reg  <= 1'b0;
			poll_reg     <= 1'b0;
			shadow_reg   <= CFG_RESET;
			smask_reg    <= MASK_RESET;
			laddr_reg    <= '0;
			lwdata_reg   <= BYTE_ZERO;
			lwr_reg      <= 1'b0;
			lrd_reg      <= 1'b0;
		end else begin
			lwr_reg <= 1'b0;
			lrd_reg <= 1'b0;
			if (take_wr && AVS_ADDRESS == AV_ACC_ADDR) begin
				acc_addr_reg <= AVS_WRITEDATA[15:0];
			end
			if (take_wr && AVS_ADDRESS == AV_OFFSET) begin
				offset_reg <= AVS_WRITEDATA;
			end
			if (take_wr && AVS_ADDRESS == AV_ACC_DATA) begin
				lwr_reg    <= 1'b1;
				laddr_reg  <= acc_addr_reg;
				lwdata_reg <= AVS_WRITEDATA[7:0];
				shadow_reg <= put_byte(shadow_reg, acc_addr_reg,
				                       AVS_WRITEDATA[7:0]);
				if (acc_addr_reg == MASK_LO) begin
					smask_reg <= AVS_WRITEDATA[NUM_SYNTH-1:0];
				end
			end
			// refusal set beats a same-cycle clear
			if (take_wr && AVS_ADDRESS == AV_STATUS
			    && AVS_WRITEDATA[ST_REFUSED]) begin
				refused_reg <= 1'b0;
			end
			if ((mb_rd_req && !mb_rd_ok) || (mb_wr_req && !mb_wr_ok)) begin
				refused_reg <= 1'b1;
			end
			if ((mb_rd_req && mb_rd_ok) || (mb_wr_req && mb_wr_ok)) begin
				lwr_reg    <= 1'b1;
				laddr_reg  <= CMD;
				lwdata_reg <= mb_rd_req ? (8'h01 << CMD_RD_BIT)
				                        : (8'h01 << CMD_WR_BIT);
				state_reg  <= H_POLL;
			end else if (take_wr && AVS_ADDRESS == AV_CONTROL
			             && AVS_WRITEDATA[CTL_LINK_RD]) begin
				lrd_reg   <= 1'b1;
				laddr_reg <= acc_addr_reg;
				poll_reg  <= 1'b0;
				state_reg <= H_WAIT;
			end
			if (state_reg == H_POLL) begin
				lrd_reg   <= 1'b1;
				laddr_reg <= CMD;
				poll_reg  <= 1'b1;
				state_reg <= H_WAIT;
			end
			// done only once the command reads back zero
			if (got_answer && poll_reg) begin
				state_reg <= (LINK.rdata == CMD_IDLE) ? H_IDLE
				                                      : H_POLL;
			end
			if (got_answer && !poll_reg) begin
				last_reg   <= LINK.rdata;
				shadow_reg <= put_byte(shadow_reg, laddr_reg,
				                       LINK.rdata);
				state_reg  <= H_IDLE;
				if (laddr_reg == MASK_LO) begin
					smask_reg <= LINK.rdata[NUM_SYNTH-1:0];
				end
			end
		end
	end

	assign AVS_READDATA    = rdata_reg;
	assign AVS_WAITREQUEST = wait_reg;
	assign LINK.addr       = laddr_reg;
	assign LINK.wdata      = lwdata_reg;
	assign LINK.wr         = lwr_reg;
	assign LINK.rd         = lrd_reg;
endmodule
`default_nettype wire

// *** core/scmb_if.sv ***
// byte register link between host controller and mailbox device
`timescale 1ns/10ps
`default_nettype none
interface scmb_if;
	logic [15:0] addr;
	logic        wr;
	logic        rd;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        rvalid;
	modport dev  (input addr, wr, rd, wdata, output rdata, rvalid);
	modport host (output addr, wr, rd, wdata, input rdata, rvalid);
endinterface
`default_nettype wire

// *** core/scmb_pkg.sv ***
// constants, types and helpers shared by both mailbox ends
package scmb_pkg;
	localparam int NUM_SYNTH = 5;
	localparam int IDX_W     = 3;
	typedef logic [15:0]          scmb_addr_type;
	typedef logic [7:0]           scmb_byte_type;
	typedef logic [NUM_SYNTH-1:0] scmb_mask_type;
	typedef logic [IDX_W-1:0]     scmb_idx_type;
	typedef struct packed {
		logic [15:0] base;
		logic [31:0] mult;
		logic [15:0] num;
		logic [15:0] den;
	} scmb_cfg_type;
	// mailbox page, byte addresses
	localparam scmb_addr_type MASK_LO = 16'h0682;
	localparam scmb_addr_type MASK_HI = 16'h0683;
	localparam scmb_addr_type CMD     = 16'h0684;
	localparam scmb_addr_type BASE_LO = 16'h0686;
	localparam scmb_addr_type BASE_HI = 16'h0687;
	localparam scmb_addr_type MULT_B0 = 16'h0688;
	localparam scmb_addr_type MULT_B1 = 16'h0689;
	localparam scmb_addr_type MULT_B2 = 16'h068a;
	localparam scmb_addr_type MULT_B3 = 16'h068b;
	localparam scmb_addr_type NUM_LO  = 16'h068c;
	localparam scmb_addr_type NUM_HI  = 16'h068d;
	localparam scmb_addr_type DEN_LO  = 16'h068e;
	localparam scmb_addr_type DEN_HI  = 16'h068f;
	localparam int            CMD_RD_BIT = 1;
	localparam int            CMD_WR_BIT = 0;
	localparam scmb_byte_type CMD_IDLE   = 8'h00;
	localparam scmb_byte_type CMD_USED   = 8'h03;
	localparam scmb_byte_type BYTE_ZERO  = 8'h00;
	localparam scmb_mask_type MASK_RESET = 5'h01;
	localparam scmb_idx_type  IDX_FIRST  = 3'h0;
	localparam scmb_idx_type  IDX_LAST   = 3'h4;
	localparam scmb_cfg_type  CFG_RESET  = '{base: 16'h0001,
		mult: 32'h12a05f20, num: 16'h0001, den: 16'h0001};
	// frequency limits in hz
	localparam logic [63:0] REF_HZ    = 64'h1dcd6500;
	localparam logic [63:0] FMIN_HZ   = 64'h0b2d05e0;
	localparam logic [63:0] FMAX_HZ   = 64'h2cb41780;
	localparam logic [63:0] MARGIN_HZ = 64'h000186a0;
	// host avalon word offsets and bits
	localparam logic [2:0] AV_ACC_ADDR = 3'h0;
	localparam logic [2:0] AV_ACC_DATA = 3'h1;
	localparam logic [2:0] AV_CONTROL  = 3'h2;
	localparam logic [2:0] AV_STATUS   = 3'h3;
	localparam logic [2:0] AV_OFFSET   = 3'h4;
	localparam int CTL_LINK_RD = 0;
	localparam int CTL_MB_RD   = 1;
	localparam int CTL_MB_WR   = 2;
	localparam int ST_REFUSED  = 1;
	typedef enum logic [2:0] {
		DEV_IDLE  = 3'b001,
		DEV_READ  = 3'b010,
		DEV_WRITE = 3'b100
	} scmb_dev_state_type;
	typedef enum logic [2:0] {
		H_IDLE = 3'b001,
		H_POLL = 3'b010,
		H_WAIT = 3'b100
	} scmb_host_state_type;

	function automatic scmb_cfg_type put_byte(scmb_cfg_type c,
		scmb_addr_type a, scmb_byte_type d);
		scmb_cfg_type r;
		r = c;
		case (a)
			BASE_LO: r.base[7:0]   = d;
			BASE_HI: r.base[15:8]  = d;
			MULT_B0: r.mult[7:0]   = d;
			MULT_B1: r.mult[15:8]  = d;
			MULT_B2: r.mult[23:16] = d;
			MULT_B3: r.mult[31:24] = d;
			NUM_LO:  r.num[7:0]    = d;
			NUM_HI:  r.num[15:8]   = d;
			DEN_LO:  r.den[7:0]    = d;
			DEN_HI:  r.den[15:8]   = d;
			default: r = c;
		endcase
		return r;
	endfunction

	function automatic scmb_byte_type get_byte(scmb_cfg_type c,
		scmb_addr_type a);
		case (a)
			BASE_LO: return c.base[7:0];
			BASE_HI: return c.base[15:8];
			MULT_B0: return c.mult[7:0];
			MULT_B1: return c.mult[15:8];
			MULT_B2: return c.mult[23:16];
			MULT_B3: return c.mult[31:24];
			NUM_LO:  return c.num[7:0];
			NUM_HI:  return c.num[15:8];
			DEN_LO:  return c.den[7:0];
			DEN_HI:  return c.den[15:8];
			default: return BYTE_ZERO;
		endcase
	endfunction

	function automatic logic is_onehot(scmb_mask_type m);
		return (m != '0) && ((m & (m - 5'h01)) == '0);
	endfunction

	function automatic scmb_idx_type lowest_index(scmb_mask_type m);
		scmb_idx_type r;
		r = IDX_FIRST;
		for (int i = NUM_SYNTH - 1; i >= 0; i--) begin
			if (m[i]) begin
				r = scmb_idx_type'(i);
			end
		end
		return r;
	endfunction

	// base x mult x num / den, zero when den is zero
	function automatic logic [31:0] freq_hz(scmb_cfg_type c);
		logic [63:0] p;
		p = 64'(c.base) * 64'(c.mult) * 64'(c.num);
		if (c.den == '0) begin
			return '0;
		end
		return 32'(p / 64'(c.den));
	endfunction
endpackage

// *** core/scmb_synth_bank.sv ***
// stored configuration of the five synthesizers
`timescale 1ns/10ps
`default_nettype none
module scmb_synth_bank (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst,
	// apply port
	input  wire logic                   wr_en,
	input  wire scmb_pkg::scmb_idx_type wr_idx,
	input  wire scmb_pkg::scmb_cfg_type wr_cfg,
	// fetch port
	input  wire scmb_pkg::scmb_idx_type rd_idx,
	output var  scmb_pkg::scmb_cfg_type rd_cfg,
	output var  scmb_pkg::scmb_cfg_type [scmb_pkg::NUM_SYNTH-1:0] all_cfg
);
	import scmb_pkg::*;
	scmb_cfg_type [NUM_SYNTH-1:0] cfg_reg;

	assign rd_cfg  = cfg_reg[rd_idx];
	assign all_cfg = cfg_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_SYNTH; i++) begin
				cfg_reg[i] <= CFG_RESET;
			end
		end else if (wr_en) begin
			cfg_reg[wr_idx] <= wr_cfg;
		end
	end
endmodule
`default_nettype wire

// *** verification/scmb_chk.sv ***
// concurrent checks on the byte link between host and mailbox device
`timescale 1ns/10ps
`default_nettype none
module scmb_chk (
	// clock and reset
	input wire logic        CORE_CLK,
	input wire logic        RST,
	// link signals
	input wire logic [15:0] addr,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [7:0]  wdata,
	input wire logic [7:0]  rdata,
	input wire logic        rvalid
);
	import scmb_pkg::*;
	logic [3:0] since_reg;
	logic [3:0] since_next;
	logic [7:0] last_cmd_reg;
	logic [7:0] last_cmd_next;
	logic       touched_reg;
	logic       touched_next;
	wire        cmd_wr   = wr && addr == CMD;
	wire        cmd_poll = rd && addr == CMD;
	// age saturates so long waits never wrap back to a young value
	assign since_next    = cmd_wr ? 4'h0 :
		since_reg + {3'h0, since_reg != 4'hf};
	assign last_cmd_next = cmd_wr ? wdata : last_cmd_reg;
	assign touched_next  = touched_reg | wr;
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			since_reg    <= 4'hf;
			last_cmd_reg <= 8'h00;
			touched_reg  <= 1'b0;
		end else begin
			since_reg    <= since_next;
			last_cmd_reg <= last_cmd_next;
			touched_reg  <= touched_next;
		end
	end
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// a poll well after the command was given must see it cleared
	sequence s_read_done;
		cmd_poll && last_cmd_reg[CMD_RD_BIT] && since_reg >= 4'h2;
	endsequence
	sequence s_write_done;
		cmd_poll && last_cmd_reg == 8'h01 && since_reg >= 4'h6;
	endsequence
	sequence s_idle_answer;
		rvalid && rdata == CMD_IDLE;
	endsequence
	property p_rvalid_after_rd;
		rd |=> rvalid;
	endproperty
	a_rvalid_after_rd: assert property (p_rvalid_after_rd)
		else $error("read strobe without answer");
	property p_rvalid_cause;
		rvalid |-> $past(rd);
	endproperty
	a_rvalid_cause: assert property (p_rvalid_cause)
		else $error("answer without read strobe");
	property p_rdata_holds;
		!rd |=> $stable(rdata);
	endproperty
	a_rdata_holds: assert property (p_rdata_holds)
		else $error("read byte changed without a read");
	property p_cmd_reserved;
		cmd_poll |=> rdata[7:2] == 6'h00;
	endproperty
	a_cmd_reserved: assert property (p_cmd_reserved)
		else $error("reserved command bits read nonzero");
	property p_mask_field;
		rd && addr == MASK_LO |=> rdata[7:5] == 3'h0;
	endproperty
	a_mask_field: assert property (p_mask_field)
		else $error("mask wider than five bits");
	property p_base_reset;
		rd && !touched_reg && addr == BASE_LO |=> rdata == 8'h01;
	endproperty
	a_base_reset: assert property (p_base_reset)
		else $error("base term reset value wrong");
	property p_mult_reset;
		rd && !touched_reg && addr == MULT_B3 |=> rdata == 8'h12;
	endproperty
	a_mult_reset: assert property (p_mult_reset)
		else $error("multiplier reset value wrong");
	property p_read_done;
		s_read_done |=> s_idle_answer;
	endproperty
	a_read_done: assert property (p_read_done)
		else $error("command not cleared after read");
	property p_write_done;
		s_write_done |=> s_idle_answer;
	endproperty
	a_write_done: assert property (p_write_done)
		else $error("command not cleared after write");
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// bench driving the host over avalon with the device on the far side
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import scmb_pkg::*;
	localparam int LIM = 4000;
	logic                       CORE_CLK;
	logic                       RST;
	logic [2:0]                 av_address;
	logic                       av_read;
	logic                       av_write;
	logic [31:0]                av_writedata;
	logic [31:0]                av_readdata;
	logic                       av_waitrequest;
	logic [NUM_SYNTH-1:0][31:0] synth_freq;
	logic                       busy;
	scmb_cfg_type               model [NUM_SYNTH];
	scmb_cfg_type               c;
	scmb_mask_type              m;
	logic [31:0]                f;
	logic [31:0]                exp_q [$];
	logic [31:0]                msk_q [$];
	int                         n_mismatch;
	int                         n_checks;
	int                         bt [3] = '{1, 2, 5};
	int                         nt [3] = '{1, 3, 2};
	int                         dt [3] = '{1, 2, 3};
	logic [15:0]                rb [5] = '{16'h3, 16'h1, 16'h1, 16'h1, 16'h1};
	logic [31:0]                rm [5] = '{32'h05f5e100, 32'h05f5e100,
		32'h0b2dc930, 32'h0ee6b280, 32'h2faf0800};
	logic [31:0]                ro [5] = '{32'h0, 32'h0, 32'h0,
		32'h05f5e100, 32'h05f5e100};
	logic [31:0]                rs [5] = '{32'h6, 32'ha, 32'ha, 32'ha, 32'h0};

	scmb_if i_scmb_if ();
	scmb_host i_scmb_host (.CORE_CLK(CORE_CLK), .RST(RST),
		.AVS_ADDRESS(av_address), .AVS_READ(av_read), .AVS_WRITE(av_write),
		.AVS_WRITEDATA(av_writedata), .AVS_READDATA(av_readdata),
		.AVS_WAITREQUEST(av_waitrequest), .LINK(i_scmb_if));
	scmb_device i_scmb_device (.CORE_CLK(CORE_CLK), .RST(RST),
		.LINK(i_scmb_if), .SYNTH_FREQ(synth_freq), .BUSY(busy));
	scmb_chk i_scmb_chk (.CORE_CLK(CORE_CLK), .RST(RST),
		.addr(i_scmb_if.addr), .wr(i_scmb_if.wr), .rd(i_scmb_if.rd),
		.wdata(i_scmb_if.wdata), .rdata(i_scmb_if.rdata),
		.rvalid(i_scmb_if.rvalid));

	always #25 CORE_CLK = ~CORE_CLK;

	task automatic chk(input string what, input logic [31:0] e, s);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, e, s);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// request held until waitrequest is sampled low, then one idle edge
	task automatic av_req(input logic r, input logic [2:0] a,
		input logic [31:0] d);
		int n;
		av_address   <= a;
		av_writedata <= d;
		av_read      <= r;
		av_write     <= !r;
		n = 0;
		do begin
			@(posedge CORE_CLK);
			n++;
		end while (av_waitrequest !== 1'b0 && n < LIM);
		if (av_waitrequest !== 1'b0) begin
			chk("waitrequest", 32'h0, 32'h1);
			wrap_up();
		end
		av_read  <= 1'b0;
		av_write <= 1'b0;
		@(posedge CORE_CLK);
	endtask

	task automatic av_rd(input logic [2:0] a, input logic [31:0] e, k);
		exp_q.push_back(e & k);
		msk_q.push_back(k);
		av_req(1'b1, a, 32'h0);
	endtask

	task automatic lw(input scmb_addr_type a, input scmb_byte_type d);
		av_req(1'b0, AV_ACC_ADDR, 32'(a));
		av_req(1'b0, AV_ACC_DATA, 32'(d));
	endtask

	task automatic lr(input scmb_addr_type a, input scmb_byte_type e);
		av_req(1'b0, AV_ACC_ADDR, 32'(a));
		av_req(1'b0, AV_CONTROL, 32'h1 << CTL_LINK_RD);
		av_rd(AV_ACC_DATA, 32'(e), 32'hff);
	endtask

	// page bytes are contiguous from the base term upward, low byte first
	task automatic pg(input scmb_cfg_type p, input logic rd_back);
		logic [79:0] v;
		v = {p.den, p.num, p.mult, p.base};
		for (int k = 0; k < 10; k++) begin
			if (rd_back)
				lr(BASE_LO + 16'(k), v[8*k +: 8]);
			else
				lw(BASE_LO + 16'(k), v[8*k +: 8]);
		end
	endtask

	task automatic fchk();
		for (int i = 0; i < NUM_SYNTH; i++) begin
			chk("synth_freq", 32'((64'(model[i].base) * 64'(model[i].mult)
				* 64'(model[i].num)) / 64'(model[i].den)), synth_freq[i]);
		end
		chk("busy", 32'h0, 32'(busy));
	endtask

	always @(posedge CORE_CLK) begin
		if (av_read && av_waitrequest === 1'b0 && exp_q.size() > 0) begin
			chk("readdata", exp_q.pop_front(), av_readdata & msk_q.pop_front());
		end
	end

	initial begin
		CORE_CLK     = 1'b0;
		RST          = 1'b1;
		av_address   = 3'h0;
		av_read      = 1'b0;
		av_write     = 1'b0;
		av_writedata = 32'h0;
		n_mismatch   = 0;
		n_checks     = 0;
		foreach (model[i]) model[i] = CFG_RESET;
		void'($urandom(58));
		repeat (20) @(posedge CORE_CLK);
		RST <= 1'b0;
		repeat (2) @(posedge CORE_CLK);
		fchk();
		pg(CFG_RESET, 1'b1);
		lr(CMD, CMD_IDLE);
		lr(MASK_LO, 8'h01);
		lw(CMD, 8'hfc);
		lr(CMD, CMD_IDLE);
		lw(MASK_HI, 8'hff);
		lr(MASK_HI, 8'h00);
		lw(MASK_LO, 8'hff);
		lr(MASK_LO, 8'h1f);
		for (int k = 0; k < 3; k++) begin
			m = 5'(1 + $urandom % 31);
			f = 32'h0bebc200 + $urandom % 32'h1dcd6500;
			c = '{base: 16'(bt[k]), mult: 32'((f / bt[k] / nt[k]) * dt[k]),
				num: 16'(nt[k]), den: 16'(dt[k])};
			pg(c, 1'b0);
			lw(MASK_LO, 8'(m));
			av_req(1'b0, AV_CONTROL, 32'h1 << CTL_MB_WR);
			for (int i = 0; i < NUM_SYNTH; i++) if (m[i]) model[i] = c;
			lr(CMD, CMD_IDLE);
			fchk();
		end
		for (int i = 0; i < NUM_SYNTH; i++) begin
			lw(MASK_LO, 8'(1 << i));
			av_req(1'b0, AV_CONTROL, 32'h1 << CTL_MB_RD);
			lr(CMD, CMD_IDLE);
			pg(model[i], 1'b1);
		end
		// both request bits at once: page reloads, no synth changes
		c = model[0];
		c.mult = 32'h11223344;
		pg(c, 1'b0);
		lw(MASK_LO, 8'h04);
		lw(CMD, 8'h03);
		lr(CMD, CMD_IDLE);
		pg(model[2], 1'b1);
		fchk();
		lw(MASK_LO, 8'h1f);
		for (int r = 0; r < 5; r++) begin
			c = '{base: rb[r], mult: rm[r], num: 16'h1, den: 16'h1};
			pg(c, 1'b0);
			av_req(1'b0, AV_OFFSET, ro[r]);
			av_req(1'b0, AV_CONTROL, 32'h1 << CTL_MB_WR);
			av_rd(AV_STATUS, rs[r], 32'he);
			if (rs[r] == 32'h0) foreach (model[i]) model[i] = c;
			av_req(1'b0, AV_STATUS, 32'h2);
			fchk();
		end
		lw(MASK_LO, 8'h03);
		av_req(1'b0, AV_CONTROL, 32'h1 << CTL_MB_RD);
		av_rd(AV_STATUS, 32'h2, 32'h2);
		// reset in mid-run must bring back the documented defaults
		RST <= 1'b1;
		repeat (3) @(posedge CORE_CLK);
		RST <= 1'b0;
		repeat (2) @(posedge CORE_CLK);
		foreach (model[i]) model[i] = CFG_RESET;
		fchk();
		lr(CMD, CMD_IDLE);
		lr(MULT_B3, 8'h12);
		chk("queue", 32'h0, 32'(exp_q.size()));
		wrap_up();
	end
endmodule
`default_nettype wire
